/* pkg/pfm_pkg.sv */
// What this block does
// R1 - PA.8 selects serial bus data line
// R2 - PA.7 decodes bus, select, converter
// R3 - PA.6 decodes bus or converter input
// R4 - PA.5..2 decode high byte, bus, converter
// R5 - PA.0 selects converter channel zero
// R6 - port B upper bits enable Schmitt inputs
// R7 - PB.15 decodes interrupt or timer capture
// R8 - PB.14 decodes interrupt or port select
// R9 - PB.13 decodes comparator or bus bit
// R10 - PB.12 decodes comparator, clock, bus bit
// R11 - PB.11..9 decode timer inputs or alternates
// R12 - PB.8 selects timer count clock input
// R13 - PB.3 decodes send-clear, strobe, capture
// R14 - PB.2 decodes send-request, strobe, capture
// R15 - PC.15..14 decode comparator or bus bits
// R16 - PC.13 selects second serial output line
// R17 - port B register at 0x34, zero reset
// R18 - port C register at 0x38, zero reset
// R19 - port A register at 0x30, zero reset
// R20 - unlisted encodings fall back to GPIO
package pfm_pkg;
    localparam logic [7:0]  PFM_OFS_PORT_A = 8'h30;
    localparam logic [7:0]  PFM_OFS_PORT_B = 8'h34;
    localparam logic [7:0]  PFM_OFS_PORT_C = 8'h38;
    localparam logic [7:0]  PFM_OFS_ALT    = 8'h50;
    localparam logic [31:0] PFM_RESET_VAL  = 32'h0000_0000;
    localparam int PFM_TYPE_LO    = 16;
    localparam int PFM_BUS_EN     = 11;
    localparam int PFM_PA7_ALT    = 2;
    localparam int PFM_HB_LO      = 16;
    localparam int PFM_PB15_ALT   = 24;
    localparam int PFM_PB14_ALT   = 3;
    localparam int PFM_PB12_ALT   = 12;
    localparam int PFM_PB11_ALT   = 4;
    localparam int PFM_PB10_ALT   = 0;
    localparam int PFM_PB9_ALT    = 1;
    localparam int PFM_WRH_EN     = 14;
    localparam int PFM_WRL_EN     = 13;
    localparam int PFM_PB3_ALT    = 27;
    localparam int PFM_PB2_ALT    = 26;

    typedef enum logic [2:0] {
        PFM_GPIO   = 3'b000,
        PFM_FUNC_A = 3'b001,
        PFM_FUNC_B = 3'b010,
        PFM_FUNC_C = 3'b011
    } pfm_func_e;
endpackage

/* design/pfm_mux.sv */
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
module pfm_mux
    import pfm_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                reset_n,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_write,
    input  wire logic                reg_read,
    output logic      [31:0]         reg_rdata,
    output logic      [15:0]         port_a_schmitt_enables,
    output logic      [15:0]         port_b_schmitt_enables,
    output logic      [15:0]         port_c_schmitt_enables,
    output pfm_func_e                pa_func [16],
    output pfm_func_e                pb_func [16],
    output pfm_func_e                pc_func [16]
);

    // function codes per pin: A first peripheral, B second, C third
    // pa 8:     A serial bus data line
    // pa 7:     A converter input 7, B port 2 second select,
    //           C bus address/data 6
    // pa 6:     A converter input 6, C bus address/data 7
    // pa 5..2:  A converter inputs 5..2, C bus address/data 8..11
    // pa 0:     A converter input 0
    // pb 15:    A external interrupt 1, C timer 0 capture input
    // pb 14:    A external interrupt 0, C port 3 second select
    // pb 13:    A comparator 1 output, C bus address/data 1
    // pb 12:    A comparator 0 output, B clock driver output,
    //           C bus address/data 0
    // pb 11..9: A timer count inputs 3..1,
    //           C pulse channel 4, port 0 and port 1 second selects
    // pb 8:     A timer 0 count input
    // pb 3/2:   A send clear / send request, B high / low write strobe,
    //           C timer 3 / timer 2 capture
    // pc 15/14: A comparator 1 negative / positive input,
    //           C bus address/data 3 / 2
    // pc 13:    A serial peripheral 1 second data out
    // every pin or code not listed stays general I/O
    typedef struct packed {
        logic [31:0] port_a;
        logic [31:0] port_b;
        logic [31:0] port_c;
        logic [31:0] alt;
        logic [31:0] rdata;
        logic [47:0] schm;
        logic [95:0] func;
    } pfm_state_s;

    pfm_state_s st_reg;
    pfm_state_s st_next;

    function automatic logic [1:0] pfm_f(input pfm_func_e f);
        return f[1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        logic [31:0] m;
        logic        e;
        pfm_func_e   fa [16];
        pfm_func_e   fb [16];
        pfm_func_e   fc [16];
        logic [3:0]  ext_bus_high_byte_enable;
        logic        pa7_port2_select1_alt;
        logic        pb15_timer0_capture_alt;
        logic        pb14_port3_select1_alt;
        logic        pb12_clock_out_alt;
        logic        pb11_pulse_ch4_alt;
        logic        pb10_port0_select1_alt;
        logic        pb9_port1_select1_alt;
        logic        ext_bus_write_high_enable;
        logic        ext_bus_write_low_enable;
        logic        pb3_timer3_capture_alt;
        logic        pb2_timer2_capture_alt;
        a = 32'h0;
        b = 32'h0;
        c = 32'h0;
        m = 32'h0;
        e = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            fa[i] = PFM_GPIO;                               // [R20]
            fb[i] = PFM_GPIO;                               // [R20]
            fc[i] = PFM_GPIO;                               // [R20]
        end
        ext_bus_high_byte_enable  = 4'h0;
        pa7_port2_select1_alt     = 1'b0;
        pb15_timer0_capture_alt   = 1'b0;
        pb14_port3_select1_alt    = 1'b0;
        pb12_clock_out_alt        = 1'b0;
        pb11_pulse_ch4_alt        = 1'b0;
        pb10_port0_select1_alt    = 1'b0;
        pb9_port1_select1_alt     = 1'b0;
        ext_bus_write_high_enable = 1'b0;
        ext_bus_write_low_enable  = 1'b0;
        pb3_timer3_capture_alt    = 1'b0;
        pb2_timer2_capture_alt    = 1'b0;
        st_next = st_reg;
        if (reg_write)
        begin
            if (reg_addr == PFM_OFS_PORT_A)
            begin
                st_next.port_a = reg_wdata;                 // [R19]
            end
            else if (reg_addr == PFM_OFS_PORT_B)
            begin
                st_next.port_b = reg_wdata;                 // [R17]
            end
            else if (reg_addr == PFM_OFS_PORT_C)
            begin
                st_next.port_c = reg_wdata;                 // [R18]
            end
            else if (reg_addr == PFM_OFS_ALT)
            begin
                st_next.alt = reg_wdata;
            end
        end
        st_next.rdata = 32'h0;
        if (reg_read)
        begin
            if (reg_addr == PFM_OFS_PORT_A)
            begin
                st_next.rdata = st_reg.port_a;
            end
            else if (reg_addr == PFM_OFS_PORT_B)
            begin
                st_next.rdata = st_reg.port_b;
            end
            else if (reg_addr == PFM_OFS_PORT_C)
            begin
                st_next.rdata = st_reg.port_c;
            end
            else if (reg_addr == PFM_OFS_ALT)
            begin
                st_next.rdata = st_reg.alt;
            end
        end

        // decode from the values that will be held next cycle
        a = st_next.port_a;
        b = st_next.port_b;
        c = st_next.port_c;
        m = st_next.alt;
        e = m[PFM_BUS_EN];
        ext_bus_high_byte_enable  = m[PFM_HB_LO +: 4];
        pa7_port2_select1_alt     = m[PFM_PA7_ALT];
        pb15_timer0_capture_alt   = m[PFM_PB15_ALT];
        pb14_port3_select1_alt    = m[PFM_PB14_ALT];
        pb12_clock_out_alt        = m[PFM_PB12_ALT];
        pb11_pulse_ch4_alt        = m[PFM_PB11_ALT];
        pb10_port0_select1_alt    = m[PFM_PB10_ALT];
        pb9_port1_select1_alt     = m[PFM_PB9_ALT];
        ext_bus_write_high_enable = m[PFM_WRH_EN];
        ext_bus_write_low_enable  = m[PFM_WRL_EN];
        pb3_timer3_capture_alt    = m[PFM_PB3_ALT];
        pb2_timer2_capture_alt    = m[PFM_PB2_ALT];
        if (a[8])
        begin
            fa[8] = PFM_FUNC_A;                             // [R1]
        end
        case ({e, pa7_port2_select1_alt, a[7]})             // [R2]
            3'b001: fa[7] = PFM_FUNC_A;
            3'b011: fa[7] = PFM_FUNC_B;
            3'b101: fa[7] = PFM_FUNC_C;
            default: fa[7] = PFM_GPIO;
        endcase
        case ({e, a[6]})                                    // [R3]
            2'b01: fa[6] = PFM_FUNC_A;
            2'b11: fa[6] = PFM_FUNC_C;
            default: fa[6] = PFM_GPIO;
        endcase
        for (int k = 0; k < 4; k++)
        begin
            case ({ext_bus_high_byte_enable[k], e, a[5 - k]}) // [R4]
                3'b001: fa[5 - k] = PFM_FUNC_A;
                3'b111: fa[5 - k] = PFM_FUNC_C;
                default: fa[5 - k] = PFM_GPIO;
            endcase
        end
        if (a[0])
        begin
            fa[0] = PFM_FUNC_A;                             // [R5]
        end
        case ({pb15_timer0_capture_alt, b[15]})             // [R7]
            2'b01: fb[15] = PFM_FUNC_A;
            2'b11: fb[15] = PFM_FUNC_C;
            default: fb[15] = PFM_GPIO;
        endcase
        case ({pb14_port3_select1_alt, b[14]})              // [R8]
            2'b01: fb[14] = PFM_FUNC_A;
            2'b11: fb[14] = PFM_FUNC_C;
            default: fb[14] = PFM_GPIO;
        endcase
        case ({e, b[13]})                                   // [R9]
            2'b01: fb[13] = PFM_FUNC_A;
            2'b11: fb[13] = PFM_FUNC_C;
            default: fb[13] = PFM_GPIO;
        endcase
        case ({e, pb12_clock_out_alt, b[12]})               // [R10]
            3'b001: fb[12] = PFM_FUNC_A;
            3'b011: fb[12] = PFM_FUNC_B;
            3'b101: fb[12] = PFM_FUNC_C;
            default: fb[12] = PFM_GPIO;
        endcase
        case ({pb11_pulse_ch4_alt, b[11]})                  // [R11]
            2'b01: fb[11] = PFM_FUNC_A;
            2'b11: fb[11] = PFM_FUNC_C;
            default: fb[11] = PFM_GPIO;
        endcase
        case ({pb10_port0_select1_alt, b[10]})              // [R11]
            2'b01: fb[10] = PFM_FUNC_A;
            2'b11: fb[10] = PFM_FUNC_C;
            default: fb[10] = PFM_GPIO;
        endcase
        case ({pb9_port1_select1_alt, b[9]})                // [R11]
            2'b01: fb[9] = PFM_FUNC_A;
            2'b11: fb[9] = PFM_FUNC_C;
            default: fb[9] = PFM_GPIO;
        endcase
        if (b[8])
        begin
            fb[8] = PFM_FUNC_A;                             // [R12]
        end
        case ({ext_bus_write_high_enable, e, b[3],
               pb3_timer3_capture_alt})                     // [R13]
            4'b0010: fb[3] = PFM_FUNC_A;
            4'b1110: fb[3] = PFM_FUNC_B;
            4'b0011: fb[3] = PFM_FUNC_C;
            default: fb[3] = PFM_GPIO;
        endcase
        case ({ext_bus_write_low_enable, e, b[2],
               pb2_timer2_capture_alt})                     // [R14]
            4'b0010: fb[2] = PFM_FUNC_A;
            4'b1110: fb[2] = PFM_FUNC_B;
            4'b0011: fb[2] = PFM_FUNC_C;
            default: fb[2] = PFM_GPIO;
        endcase
        for (int k = 14; k < 16; k++)
        begin
            case ({e, c[k]})                                // [R15]
                2'b01: fc[k] = PFM_FUNC_A;
                2'b11: fc[k] = PFM_FUNC_C;
                default: fc[k] = PFM_GPIO;
            endcase
        end
        if (c[13])
        begin
            fc[13] = PFM_FUNC_A;                            // [R16]
        end
        st_next.schm = {c[31:PFM_TYPE_LO], b[31:PFM_TYPE_LO],
                        a[31:PFM_TYPE_LO]};                 // [R6]
        for (int i = 0; i < 16; i++)
        begin
            st_next.func[i * 2 +: 2]      = pfm_f(fa[i]);
            st_next.func[32 + i * 2 +: 2] = pfm_f(fb[i]);
            st_next.func[64 + i * 2 +: 2] = pfm_f(fc[i]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_reg <= '0;                                   // [R17] [R18]
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign reg_rdata              = st_reg.rdata;
    assign port_a_schmitt_enables = st_reg.schm[15:0];
    assign port_b_schmitt_enables = st_reg.schm[31:16];     // [R6]
    assign port_c_schmitt_enables = st_reg.schm[47:32];
    always_comb
    begin
        for (int i = 0; i < 16; i++)
        begin
            pa_func[i] = pfm_func_e'({1'b0, st_reg.func[i * 2 +: 2]});
            pb_func[i] = pfm_func_e'({1'b0, st_reg.func[32 + i * 2 +: 2]});
            pc_func[i] = pfm_func_e'({1'b0, st_reg.func[64 + i * 2 +: 2]});
        end
    end

endmodule

/* test/pfm_mux_props.sv */
`timescale 1ns/100ps
module pfm_mux_props
    import pfm_pkg::*;
(
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic [15:0] port_a_schmitt_enables,
    input wire logic [15:0] port_b_schmitt_enables,
    input wire logic [15:0] port_c_schmitt_enables,
    input pfm_func_e        pa_func [16],
    input pfm_func_e        pb_func [16],
    input pfm_func_e        pc_func [16]
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic wa;
    logic wb;
    logic wc;
    assign wa = reg_write && reg_addr == PFM_OFS_PORT_A;
    assign wb = reg_write && reg_addr == PFM_OFS_PORT_B;
    assign wc = reg_write && reg_addr == PFM_OFS_PORT_C;
    function automatic pfm_func_e sel(input logic b);
        return b ? PFM_FUNC_A : PFM_GPIO;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    property p_pa8; wa |=> pa_func[8] == sel($past(reg_wdata[8])); endproperty
    property p_pa0; wa |=> pa_func[0] == sel($past(reg_wdata[0])); endproperty
    property p_pb8; wb |=> pb_func[8] == sel($past(reg_wdata[8])); endproperty
    property p_pc13;
        wc |=> pc_func[13] == sel($past(reg_wdata[13]));
    endproperty
    property p_sa;
        wa |=> port_a_schmitt_enables == $past(reg_wdata[31:16]);
    endproperty
    property p_sb;
        wb |=> port_b_schmitt_enables == $past(reg_wdata[31:16]);
    endproperty
    property p_hold; !wb |=> $stable(port_b_schmitt_enables); endproperty
    property p_rd;
        wb ##1 !wb ##1 (reg_read && reg_addr == PFM_OFS_PORT_B)
            |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    property p_idle; !reg_read |=> reg_rdata == 32'h0; endproperty
    property p_pb7; pb_func[7] == PFM_GPIO; endproperty
    a_pa8: assert property (p_pa8)
        else $error("pa8 select wrong");
    a_pa0: assert property (p_pa0)
        else $error("pa0 select wrong");
    a_pb8: assert property (p_pb8)
        else $error("pb8 select wrong");
    a_pc13: assert property (p_pc13)
        else $error("pc13 select wrong");
    a_sa: assert property (p_sa)
        else $error("port a schmitt wrong");
    a_sb: assert property (p_sb)
        else $error("port b schmitt wrong");
    a_hold: assert property (p_hold)
        else $error("port b schmitt moved");
    a_rd: assert property (p_rd)
        else $error("read back wrong");
    a_idle: assert property (p_idle)
        else $error("read data not zero");
    a_pb7: assert property (p_pb7)
        else $error("pb7 not gpio");
    c_pa7: cover property (pa_func[7] == PFM_FUNC_C);
    c_pb3: cover property (pb_func[3] == PFM_FUNC_B);
    c_alt: cover property (reg_write && reg_addr == PFM_OFS_ALT);
endmodule
bind pfm_mux pfm_mux_props i_pfm_mux_props (.clock(clock),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .port_a_schmitt_enables(port_a_schmitt_enables),
    .port_b_schmitt_enables(port_b_schmitt_enables),
    .port_c_schmitt_enables(port_c_schmitt_enables),
    .pa_func(pa_func), .pb_func(pb_func), .pc_func(pc_func));

/* test/pfm_pads.sv */
`timescale 1ns/100ps
module pfm_pads
    import pfm_pkg::*;
(
    input pfm_func_e        pb_func [16],
    output logic [4:0]      pb_active
);
    // counts port b pads handed over to a peripheral
    always_comb
    begin
        pb_active = 5'h00;
        for (int i = 0; i < 16; i++)
            pb_active += 5'(pb_func[i] != PFM_GPIO);
    end
endmodule

/* test/tb_pfm_mux.sv */
`timescale 1ns/100ps
module tb_pfm_mux;
    import pfm_pkg::*;
    logic        clock = 1'h0;
    logic        reset_n = 1'h0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_write = 1'h0;
    logic        reg_read = 1'h0;
    logic [31:0] reg_rdata;
    logic [15:0] sch_a;
    logic [15:0] sch_b;
    logic [15:0] sch_c;
    pfm_func_e   pa_func [16];
    pfm_func_e   pb_func [16];
    pfm_func_e   pc_func [16];
    logic [4:0]  pb_active;
    int          error_cnt = 0;
    int          num_checks = 0;
    localparam pfm_func_e G = PFM_GPIO;
    localparam pfm_func_e A = PFM_FUNC_A;
    localparam pfm_func_e B = PFM_FUNC_B;
    localparam pfm_func_e C = PFM_FUNC_C;
    always #50 clock = ~clock;
    pfm_mux i_pfm_mux (.clock(clock), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .port_a_schmitt_enables(sch_a), .port_b_schmitt_enables(sch_b),
        .port_c_schmitt_enables(sch_c), .pa_func(pa_func),
        .pb_func(pb_func), .pc_func(pc_func));
    pfm_pads i_pfm_pads (.pb_func(pb_func), .pb_active(pb_active));
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge clock);
        reg_write <= 1'h0;
        #1;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge clock);
        reg_read <= 1'h0;
        #1;
        d = reg_rdata;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_regs;
        logic [7:0]  ofs [5];
        logic [31:0] d;
        ofs = '{PFM_OFS_PORT_A, PFM_OFS_PORT_B, PFM_OFS_PORT_C,
                PFM_OFS_ALT, 8'h44};
        foreach (ofs[k])
        begin
            rd(ofs[k], d);
            chk(d, 32'h0);
            wr(ofs[k], 32'hc3a5_0000);
            rd(ofs[k], d);
            chk(d, k < 4 ? 32'hc3a5_0000 : 32'h0);
        end
        chk(32'(sch_a), 32'hc3a5);
    endtask
    task t_pa;
        for (int i = 0; i < 8; i++)
        begin
            wr(PFM_OFS_ALT, {12'h0, {4{i[1]}}, 4'h0, i[2], 8'h0, i[1], 2'h0});
            wr(PFM_OFS_PORT_A, i[0] ? 32'h01fd : 32'h0);
            chk(32'(pa_func[8]), 32'(i[0] ? A : G));
            chk(32'(pa_func[7]), 32'(i == 1 ? A : i == 3 ? B :
                i == 5 ? C : G));
            chk(32'(pa_func[6]), 32'(i[0] ? (i[2] ? C : A) : G));
            for (int p = 2; p < 6; p++)
                chk(32'(pa_func[p]), 32'(i == 1 ? A : i == 7 ? C : G));
            chk(32'(pa_func[0]), 32'(i[0] ? A : G));
        end
    endtask
    task t_pb;
        int pin [5] = '{15, 14, 11, 10, 9};
        pfm_func_e x;
        pfm_func_e y;
        for (int i = 0; i < 16; i++)
        begin
            wr(PFM_OFS_ALT, {4'h0, i[0], i[0], 1'h0, i[0], 8'h0, 1'h0, i[3],
                i[3], i[0], i[2], 6'h0, i[0], i[0], 1'h0, i[0], i[0]});
            wr(PFM_OFS_PORT_B, {12'h0, i[3:0], i[1] ? 16'hff0c : 16'h0});
            x = i[1] ? (i[0] ? C : A) : G;
            y = i == 2 ? A : i == 14 ? B : i == 3 ? C : G;
            foreach (pin[k])
                chk(32'(pb_func[pin[k]]), 32'(x));
            chk(32'(pb_func[13]), 32'(i[1] ? (i[2] ? C : A) : G));
            chk(32'(pb_func[12]), 32'(!i[1] || (i[2] && i[0]) ? G :
                i[2] ? C : i[0] ? B : A));
            chk(32'(pb_func[8]), 32'(i[1] ? A : G));
            chk(32'(pb_func[3]), 32'(y));
            chk(32'(pb_func[2]), 32'(y));
            chk(32'(sch_b), 32'(i));
            if (i == 2)
                chk(32'(pb_active), 32'h0a);
        end
    endtask
    task t_pc;
        pfm_func_e x;
        for (int i = 0; i < 4; i++)
        begin
            wr(PFM_OFS_ALT, {20'h0, i[1], 11'h0});
            wr(PFM_OFS_PORT_C, {14'h0, i[1:0], i[0] ? 16'he000 : 16'h0});
            x = i[0] ? (i[1] ? C : A) : G;
            chk(32'(pc_func[15]), 32'(x));
            chk(32'(pc_func[14]), 32'(x));
            chk(32'(pc_func[13]), 32'(i[0] ? A : G));
            chk(32'(sch_c), 32'(i));
        end
    endtask
    task t_rst;
        logic [31:0] d;
        wr(PFM_OFS_PORT_B, 32'h0005_8000);
        chk(32'(pb_func[15]), 32'(A));
        chk(32'(sch_b), 32'h5);
        @(posedge clock);
        reset_n <= 1'h0;
        @(posedge clock);
        reset_n <= 1'h1;
        #1;
        chk(32'(sch_b), 32'h0);
        chk(32'(pb_func[15]), 32'(G));
        rd(PFM_OFS_PORT_B, d);
        chk(d, 32'h0);
    endtask
    task close_out;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clock);
        reset_n <= 1'h1;
        t_regs;
        t_pa;
        t_pb;
        t_pc;
        t_rst;
        close_out;
    end
endmodule
